// ==== hw/supply_seq_pkg.sv ====
/*
 * Shared constants and carriers for the supply sequencer and monitor.
 * Assumes a single 20 MHz clock and synchronous comparator inputs.
 */
package supply_seq_pkg;
    // ========================================
    // regulator indices
    localparam int NREG      = 8;
    localparam int R_STBY    = 0;
    localparam int R_PRE     = 1;
    localparam int R_MCU     = 2;
    localparam int R_CORE    = 3;
    localparam int R_VREF    = 4;
    localparam int R_COMM    = 5;
    localparam int R_TRK1    = 6;
    localparam int R_TRK2    = 7;

    // ========================================
    // timing
    localparam int CLK_HZ             = 20000000;
    localparam int REACTION_TIME_NS   = 10000;
    localparam int STG_TIME_NS        = 4000000;
    localparam int OT_OFF_TIME_MS     = 1000;
    localparam int REACTION_CYC       = (REACTION_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int STG_CYC_DEF        = (STG_TIME_NS / 1000) * (CLK_HZ / 1000000);
    localparam int OT_OFF_CYC_DEF     = OT_OFF_TIME_MS * (CLK_HZ / 1000);
    localparam int FILT_W             = 8;
    localparam int STG_W              = 17;
    localparam int OT_W               = 25;
    localparam int RD_W               = 20;

    localparam logic [7:0] REG_NONE   = 8'h00;
    localparam logic [7:0] ALL_REG    = 8'hFF;
    localparam logic [7:0] SELECTABLE = 8'hF0;

    // ========================================
    // per-regulator comparator pair
    typedef struct packed {
        logic [7:0] over;
        logic [7:0] under;
    } cmp_t;

    // latched fault flags
    typedef struct packed {
        logic [7:0] shortGnd;
        logic [7:0] overV;
        logic [7:0] underV;
        logic       overTemp;
    } flags_t;

    typedef enum logic [5:0] {
        S_OFF      = 6'h01,
        S_INIT     = 6'h02,
        S_NORMAL   = 6'h04,
        S_STANDBY  = 6'h08,
        S_SLEEP    = 6'h10,
        S_SAFE_SHUTDOWN_STATE = 6'h20
    } state_t;
endpackage

// ==== hw/fault_filter.sv ====
/*
 * Comparator filter: counts while asserted, clears on drop,
 * flags at the limit.
 * Assumes a comparator synchronous to clk.
 */
`timescale 1ns/10ps
module fault_filter #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         cmpIn,
    input  wire logic         bypass,
    input  wire logic [W-1:0] limit,
    output logic              detected
);
    logic [W-1:0] count;

    // ========================================
    // counter clears when comparator drops
    always_ff @(posedge clk) begin
        if (sys_rst || !cmpIn) begin
            count <= '0;
        end else if (count != {W{1'b1}}) begin
            count <= count + 1'b1;
        end
    end

    assign detected = cmpIn && (bypass || (count >= limit));
endmodule

// ==== hw/rst_delay_timer.sv ====
/*
 * Reset-delay counter: runs while start is held, done at length.
 * Assumes start stays high until done is used.
 */
`timescale 1ns/10ps
module rst_delay_timer (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      start,
    input  wire logic [supply_seq_pkg::RD_W-1:0] length,
    output logic                           done
);
    logic [supply_seq_pkg::RD_W-1:0] count;

    // ========================================
    // count up, hold at length
    always_ff @(posedge clk) begin
        if (sys_rst || !start) begin
            count <= '0;
        end else if (count != length) begin
            count <= count + 1'b1;
        end
    end

    assign done = start && (count == length);
endmodule

// ==== hw/supply_sequencer_monitor.sv ====
/*
 * Supply sequencer and monitor: enable chain, filtered
 * supervision, reset, interrupt and core enable.
 * Assumes inputs synchronous to clk; under high means
 * output below its low threshold.
 */
// What this block does
// - at power-on release enable standby and pre regulator first together
// - pre good enables mcu LDO; mcu good drives core enable if selected
// - vref enabled after mcu good, or after core good when core selected
// - vref good enables comm, comm good tracker one, then tracker two
// - reset delay starts once standby, mcu and selected core are good
// - reset output goes high when the reset delay expires
// - standby wake enables pre regulator, reruns chain, skips standby wait
// - sleep wake starts at vref then comm, trackers; reset stays high
// - sleep wake skips LDOs off in normal state, keeps enabled ones
// - voltage limits are fixed, nothing here can change them
// - faults count only beyond reaction time; internal supplies and overtemperature unfiltered
// - undervoltage shorter than the short-to-ground time never disables its regulator
// - monitoring active only for regulators in use and switched on
// - every regulator fault and overtemperature latched into readable flag groups; internal supply fault not latched
// - overtemperature enters safe_shutdown_state, regulators off at least one second
// - standby, mcu, core and internal supply faults pull reset low
// - core overvoltage or short to ground drives core enable low
// - pre and vref overvoltage reset, undervoltage interrupt; others interrupt
// - pre short-to-ground timing only in init until first good crossing
// - main overvoltage shuts all and safe_shutdown_state; comm/tracker shuts only itself
// - long undervoltage main rails safe_shutdown_state; vref, comm, trackers shut themselves
// - vref, comm or tracker ramp failure halts sequence, reset still released after delay
// - software enable change during sequencing aborts automatic sequence
`timescale 1ns/10ps
module supply_sequencer_monitor #(
    parameter int STG_CYC    = supply_seq_pkg::STG_CYC_DEF,
    parameter int OT_OFF_CYC = supply_seq_pkg::OT_OFF_CYC_DEF
) (
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire supply_seq_pkg::cmp_t           cmp,
    input  wire logic                           intSupplyFault,
    input  wire logic                           overTemp,
    input  wire logic                           coreSelect,
    input  wire logic                           goStandby,
    input  wire logic                           goSleep,
    input  wire logic                           wakeValid,
    input  wire logic                           wakeTimer,
    input  wire logic [7:0]                     swEnable,
    input  wire logic                           swWrite,
    input  wire logic [supply_seq_pkg::RD_W-1:0] resetDelay,
    input  wire logic                           flagClear,
    output logic [7:0]                          regEnable,
    output logic                                ext_core_enable,
    output logic                                reset_out_n,
    output logic                                interruptOut,
    output supply_seq_pkg::flags_t              flags,
    output supply_seq_pkg::state_t              state
);
    import supply_seq_pkg::*;
    // ========================================
    // declarations
    logic [7:0]  ovDet;
    logic [7:0]  uvDet;
    logic [7:0]  stgDet;
    logic [7:0]  inUse;
    logic [7:0]  active;
    logic [7:0]  normalCfg;
    logic [7:0]  faultOff;
    logic        seqHalt;
    logic        preCrossed;
    logic        rdStart;
    logic        rdDone;
    logic        stbyPath;
    logic        coreOk;
    logic [OT_W-1:0] otCount;
    logic        anyFail;
    logic        rstFault;
    logic        irqFault;
    logic [7:0]  next_enable;

    // regulators that exist in this configuration
    assign inUse  = coreSelect ? ALL_REG : (ALL_REG & ~(8'h01 << R_CORE));
    assign active = regEnable & inUse;

    // ========================================
    // comparator filters
    // per-regulator filter counters
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_mon
            fault_filter #(.W(FILT_W)) u_ov (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .cmpIn    (cmp.over[gi] & active[gi]),
                .bypass   (1'b0),
                .limit    (FILT_W'(REACTION_CYC)),
                .detected (ovDet[gi])
            );
            fault_filter #(.W(FILT_W)) u_uv (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .cmpIn    (cmp.under[gi] & active[gi]),
                .bypass   (1'b0),
                .limit    (FILT_W'(REACTION_CYC)),
                .detected (uvDet[gi])
            );
            fault_filter #(.W(STG_W)) u_stg (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .cmpIn    (cmp.under[gi] & active[gi]),
                .bypass   (1'b0),
                .limit    (STG_W'(STG_CYC)),
                .detected (stgDet[gi])
            );
        end
    endgenerate

    // ========================================
    // fault classification
    // overtemperature, main rail overvoltage or long undervoltage
    assign anyFail = overTemp
        | ovDet[R_STBY] | ovDet[R_MCU] | ovDet[R_CORE] | ovDet[R_VREF] | ovDet[R_PRE]
        | stgDet[R_STBY] | stgDet[R_MCU] | stgDet[R_CORE]
        // pre short to ground only before first crossing in init
        | (stgDet[R_PRE] & ~preCrossed & (state == S_INIT));
    assign rstFault = intSupplyFault
        | ovDet[R_STBY] | uvDet[R_STBY] | ovDet[R_MCU] | uvDet[R_MCU]
        | ovDet[R_CORE] | uvDet[R_CORE]
        // pre and vref overvoltage to reset
        | ovDet[R_PRE] | ovDet[R_VREF];
    assign irqFault = uvDet[R_PRE] | uvDet[R_VREF]
        | ovDet[R_COMM] | uvDet[R_COMM] | ovDet[R_TRK1] | uvDet[R_TRK1]
        | ovDet[R_TRK2] | uvDet[R_TRK2];

    // ========================================
    // state machine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= S_OFF;
        end else begin
            case (state)
                S_OFF: begin
                    state <= S_INIT;
                end
                S_INIT, S_NORMAL: begin
                    if (anyFail) begin
                        state <= S_SAFE_SHUTDOWN_STATE;
                    end else if (state == S_INIT && reset_out_n) begin
                        state <= S_NORMAL;
                    end else if (state == S_NORMAL && goStandby) begin
                        state <= S_STANDBY;
                    end else if (state == S_NORMAL && goSleep) begin
                        state <= S_SLEEP;
                    end
                end
                S_STANDBY: begin
                    if (overTemp || ovDet[R_STBY] || stgDet[R_STBY]) begin
                        state <= S_SAFE_SHUTDOWN_STATE;
                    end else if (wakeValid || wakeTimer) begin
                        state <= S_INIT;
                    end
                end
                S_SLEEP: begin
                    if (anyFail) begin
                        state <= S_SAFE_SHUTDOWN_STATE;
                    end else if (wakeValid || wakeTimer) begin
                        state <= S_NORMAL;
                    end
                end
                S_SAFE_SHUTDOWN_STATE: begin
                    if (otCount >= OT_W'(OT_OFF_CYC) && !overTemp) begin
                        state <= S_OFF;
                    end
                end
                default: state <= S_OFF;
            endcase
        end
    end

    // ========================================
    // safe_shutdown_state off-time counter
    always_ff @(posedge clk) begin
        if (sys_rst || state != S_SAFE_SHUTDOWN_STATE) begin
            otCount <= '0;
        end else if (otCount != {OT_W{1'b1}}) begin
            otCount <= otCount + 1'b1;
        end
    end

    // ========================================
    // sequence bookkeeping
    always_ff @(posedge clk) begin
        if (sys_rst || state == S_OFF || state == S_SAFE_SHUTDOWN_STATE) begin
            preCrossed <= 1'b0;
            seqHalt    <= 1'b0;
            stbyPath   <= 1'b0;
            normalCfg  <= SELECTABLE;
        end else begin
            if (regEnable[R_PRE] && !cmp.under[R_PRE]) begin
                preCrossed <= 1'b1;
            end
            if (state == S_STANDBY) begin
                stbyPath   <= 1'b1;
                preCrossed <= 1'b0;
            end
            if (stgDet[R_VREF] || stgDet[R_COMM] || stgDet[R_TRK1] || stgDet[R_TRK2]) begin
                seqHalt <= 1'b1;
            end
            if (swWrite) begin
                seqHalt   <= 1'b1;
                normalCfg <= swEnable & SELECTABLE;
            end
            if (state == S_NORMAL && goSleep && !goStandby) begin
                normalCfg <= regEnable & SELECTABLE;
            end
            if (state == S_NORMAL) begin
                seqHalt <= 1'b0;
            end
        end
    end

    // ========================================
    // enable chain
    assign coreOk = !coreSelect || (regEnable[R_CORE] && !cmp.under[R_CORE]);
    always_comb begin
        next_enable = regEnable;
        case (state)
            S_OFF, S_SAFE_SHUTDOWN_STATE: next_enable = REG_NONE;
            S_STANDBY: next_enable = 8'h01 << R_STBY;
            S_SLEEP: next_enable = regEnable & ((8'h01 << R_STBY) | (8'h01 << R_PRE)
                                   | (8'h01 << R_MCU) | (8'h01 << R_CORE));
            default: begin
                next_enable[R_STBY] = 1'b1;
                next_enable[R_PRE]  = 1'b1;
                if (regEnable[R_PRE] && !cmp.under[R_PRE]) begin
                    next_enable[R_MCU] = 1'b1;
                end
                if (coreSelect && regEnable[R_MCU] && !cmp.under[R_MCU]) begin
                    next_enable[R_CORE] = 1'b1;
                end
                if (swWrite) begin
                    next_enable = (next_enable & ~SELECTABLE) | (swEnable & SELECTABLE);
                end else if (!seqHalt) begin
                    // vref after mcu and core good; skip when off
                    if (regEnable[R_MCU] && !cmp.under[R_MCU] && coreOk && normalCfg[R_VREF]) begin
                        next_enable[R_VREF] = 1'b1;
                    end
                    if ((!normalCfg[R_VREF] || (regEnable[R_VREF] && !cmp.under[R_VREF]))
                        && regEnable[R_MCU] && coreOk && normalCfg[R_COMM]) begin
                        next_enable[R_COMM] = 1'b1;
                    end
                    if ((!normalCfg[R_COMM] || (regEnable[R_COMM] && !cmp.under[R_COMM]))
                        && (next_enable[R_COMM] || !normalCfg[R_COMM]) && regEnable[R_MCU]
                        && coreOk && normalCfg[R_TRK1]) begin
                        next_enable[R_TRK1] = 1'b1;
                    end
                    if ((!normalCfg[R_TRK1] || (regEnable[R_TRK1] && !cmp.under[R_TRK1]))
                        && regEnable[R_MCU] && coreOk && normalCfg[R_TRK2]) begin
                        next_enable[R_TRK2] = 1'b1;
                    end
                end
                // comm/tracker overvoltage; long undervoltage shuts one
                next_enable = next_enable & ~faultOff;
            end
        endcase
    end

    // latched shutdowns; a new one beats a software clear
    always_ff @(posedge clk) begin
        if (sys_rst || state == S_OFF) begin
            faultOff <= REG_NONE;
        end else begin
            faultOff <= (swWrite ? REG_NONE : faultOff) | ((ovDet | stgDet) & 8'hE0) | (stgDet & (8'h01 << R_VREF));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regEnable <= REG_NONE;
        end else begin
            regEnable <= next_enable;
        end
    end

    // ========================================
    // core enable pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_core_enable <= 1'b0;
        end else begin
            // core off on overvoltage or short
            ext_core_enable <= next_enable[R_CORE] && coreSelect
                               && !ovDet[R_CORE] && !stgDet[R_CORE];
        end
    end

    // ========================================
    // reset delay and reset output
    // start condition; standby path skips standby rail
    assign rdStart = (state == S_INIT)
        && (stbyPath || (regEnable[R_STBY] && !cmp.under[R_STBY]))
        && regEnable[R_MCU] && !cmp.under[R_MCU] && coreOk;

    rst_delay_timer u_rd (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (rdStart),
        .length  (resetDelay),
        .done    (rdDone)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reset_out_n <= 1'b0;
        end else if (state == S_OFF || state == S_SAFE_SHUTDOWN_STATE || state == S_STANDBY
                     || anyFail || rstFault) begin
            reset_out_n <= 1'b0;
        end else if (rdDone) begin
            // release after delay; even when halted
            reset_out_n <= 1'b1;
        end
        // sleep keeps the current high level
    end

    // ========================================
    // interrupt and flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            interruptOut <= 1'b0;
        end else begin
            interruptOut <= irqFault;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= '0;
        end else begin
            flags.shortGnd <= (flagClear ? REG_NONE : flags.shortGnd) | stgDet;
            flags.overV    <= (flagClear ? REG_NONE : flags.overV) | ovDet;
            flags.underV   <= (flagClear ? REG_NONE : flags.underV) | uvDet;
            flags.overTemp <= (flagClear ? 1'b0 : flags.overTemp) | overTemp;
        end
    end
endmodule

// ==== verification/supply_seq_asserts.sv ====
/*
 * Checker: chain order, fault filters, reactions.
 * Bound to the top module; sees its ports, one clock.
 */
`timescale 1ns/10ps
module supply_seq_asserts #(
    parameter int STG_CYC    = 50,
    parameter int OT_OFF_CYC = 100
) (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire supply_seq_pkg::cmp_t   cmp,
    input wire logic                   intSupplyFault,
    input wire logic                   overTemp,
    input wire logic                   coreSelect,
    input wire logic                   swWrite,
    input wire logic                   flagClear,
    input wire logic [7:0]             regEnable,
    input wire logic                   ext_core_enable,
    input wire logic                   reset_out_n,
    input wire logic                   interruptOut,
    input wire supply_seq_pkg::flags_t flags,
    input wire supply_seq_pkg::state_t state
);
    // ========================================
    // helper counters
    logic [8:0]  overRun;
    logic [31:0] safeRun;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // run of comm overvoltage
    always_ff @(posedge clk) begin
        if (sys_rst || !cmp.over[supply_seq_pkg::R_COMM])
            overRun <= 9'h000;
        else if (overRun != 9'h1FF)
            overRun <= overRun + 9'h001;
    end
    // cycles in safe shutdown
    always_ff @(posedge clk) begin
        if (sys_rst || state != supply_seq_pkg::S_SAFE_SHUTDOWN_STATE)
            safeRun <= '0;
        else
            safeRun <= safeRun + 32'h00000001;
    end
    // interrupt, then comm off
    sequence commShut;
        ##[0:2] interruptOut ##[0:2] !regEnable[supply_seq_pkg::R_COMM];
    endsequence
    // ========================================
    // properties
    a_mcu_after_pre: assert property ($rose(regEnable[supply_seq_pkg::R_MCU]) |->
        $past(!cmp.under[supply_seq_pkg::R_PRE])) else $error("mcu before pre good");
    a_vref_after_mcu: assert property ($rose(regEnable[supply_seq_pkg::R_VREF]) && !$past(swWrite) |->
        $past(!cmp.under[supply_seq_pkg::R_MCU]) && (!coreSelect || $past(!cmp.under[supply_seq_pkg::R_CORE])))
        else $error("vref early");
    a_comm_after_vref: assert property ($rose(regEnable[supply_seq_pkg::R_COMM]) && !$past(swWrite) |->
        $past(!cmp.under[supply_seq_pkg::R_VREF])) else $error("comm before vref good");
    a_trk2_after_trk1: assert property ($rose(regEnable[supply_seq_pkg::R_TRK2]) && !$past(swWrite) |->
        $past(!cmp.under[supply_seq_pkg::R_TRK1] || !regEnable[supply_seq_pkg::R_TRK1])) else $error("trk2 early");
    a_delay_gate_good: assert property ($rose(reset_out_n) |-> $past(!cmp.under[supply_seq_pkg::R_MCU]) &&
        (!coreSelect || $past(!cmp.under[supply_seq_pkg::R_CORE]))) else $error("reset released on bad rail");
    a_int_fault_rst: assert property (intSupplyFault |=> !reset_out_n)
        else $error("int fault kept reset high");
    a_ov_filter_time: assert property ($rose(flags.overV[supply_seq_pkg::R_COMM]) |-> overRun >= 9'h0C8)
        else $error("ov flagged too soon");
    a_comm_ov_shut: assert property ($rose(flags.overV[supply_seq_pkg::R_COMM]) |-> commShut)
        else $error("comm ov not handled");
    a_core_ov_off: assert property ($rose(flags.overV[supply_seq_pkg::R_CORE]) |-> ##[0:2]
        (!ext_core_enable && state == supply_seq_pkg::S_SAFE_SHUTDOWN_STATE)) else $error("core ov kept core on");
    a_ot_safe_off: assert property ($rose(overTemp) |-> ##[1:3]
        (state == supply_seq_pkg::S_SAFE_SHUTDOWN_STATE && regEnable == 8'h00)) else $error("overtemp not shut down");
    a_ot_off_time: assert property ($fell(state == supply_seq_pkg::S_SAFE_SHUTDOWN_STATE) |-> safeRun >= OT_OFF_CYC)
        else $error("safe shutdown left too early");
    a_flag_sticky_hold: assert property (!flagClear |=> ($past(flags) & ~flags) == '0)
        else $error("flag lost without clear");
endmodule
bind supply_sequencer_monitor supply_seq_asserts #(.STG_CYC(STG_CYC), .OT_OFF_CYC(OT_OFF_CYC)) supply_seq_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .cmp(cmp), .intSupplyFault(intSupplyFault), .overTemp(overTemp),
    .coreSelect(coreSelect), .swWrite(swWrite), .flagClear(flagClear), .regEnable(regEnable),
    .ext_core_enable(ext_core_enable), .reset_out_n(reset_out_n), .interruptOut(interruptOut),
    .flags(flags), .state(state));

// ==== verification/regulator_model.sv ====
/*
 * Regulator stages: enabled outputs ramp, then read good.
 * Driven by the enables; the bench forces faults by masks.
 */
`timescale 1ns/10ps
module regulator_model #(
    parameter int RAMP = 4
) (
    input  wire logic            clk,
    input  wire logic [7:0]      regEnable,
    input  wire logic            coreOn,
    input  wire logic [7:0]      forceOver,
    input  wire logic [7:0]      forceUnder,
    output supply_seq_pkg::cmp_t cmp
);
    logic [7:0] on;
    logic [3:0] ramp [8];
    assign on = {regEnable[7:4], coreOn, regEnable[2:0]};
    // ramp restarts when switched off
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!on[i])
                ramp[i] <= 4'h0;
            else if (ramp[i] != 4'(RAMP))
                ramp[i] <= ramp[i] + 4'h1;
        end
    end
    // off or ramping stage reads under
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cmp.under[i] = forceUnder[i] || (ramp[i] != 4'(RAMP));
            cmp.over[i]  = forceOver[i];
        end
    end
endmodule

// ==== verification/supply_sequencer_monitor_tb.sv ====
/*
 * Bench: sequencer plus regulator model.
 * Assumes 20 MHz clock, short stg and off counts.
 */
`timescale 1ns/10ps
module supply_sequencer_monitor_tb;
    // ========================================
    // signals
    logic                   clk = 1'h0;
    logic                   sys_rst = 1'h1;
    logic                   intSupplyFault, overTemp, coreSelect, goStandby, goSleep, wakeValid, wakeTimer;
    logic                   swWrite, flagClear, ext_core_enable, reset_out_n, interruptOut;
    logic [7:0]             swEnable, regEnable, forceOver, forceUnder;
    logic [19:0]            resetDelay;
    supply_seq_pkg::cmp_t   cmp;
    supply_seq_pkg::flags_t flags;
    supply_seq_pkg::state_t state;
    int                     errors = 0;
    int                     tests_run = 0;
    always #25 clk = ~clk;
    supply_sequencer_monitor #(.STG_CYC(50), .OT_OFF_CYC(100)) supply_sequencer_monitor_inst (
        .clk(clk), .sys_rst(sys_rst), .cmp(cmp), .intSupplyFault(intSupplyFault), .overTemp(overTemp),
        .coreSelect(coreSelect), .goStandby(goStandby), .goSleep(goSleep), .wakeValid(wakeValid),
        .wakeTimer(wakeTimer), .swEnable(swEnable), .swWrite(swWrite), .resetDelay(resetDelay),
        .flagClear(flagClear), .regEnable(regEnable), .ext_core_enable(ext_core_enable),
        .reset_out_n(reset_out_n), .interruptOut(interruptOut), .flags(flags), .state(state));
    regulator_model regulator_model_inst (.clk(clk), .regEnable(regEnable), .coreOn(ext_core_enable),
        .forceOver(forceOver), .forceUnder(forceUnder), .cmp(cmp));
    // ========================================
    // tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check_val(input logic [24:0] got, input logic [24:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rst(input logic level);
        int n;
        n = 0;
        while (reset_out_n !== level && n < 2000) begin
            step(1);
            n++;
        end
        check_val(25'(n < 2000), 25'h0000001);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog
    initial begin
        step(8000);
        errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        tally_and_finish;
    end
    // ========================================
    // main sequence
    initial begin
        {intSupplyFault, overTemp, goStandby, goSleep, wakeValid, wakeTimer, swWrite, flagClear} = 8'h00;
        coreSelect = 1'h1;
        swEnable = 8'hF0;
        forceOver = 8'h00;
        forceUnder = 8'h00;
        resetDelay = 20'h00064;
        step(12);
        sys_rst <= 1'h0;
        step(4);
        check_val(regEnable, 8'h03);
        step(20);
        check_val(reset_out_n, 1'h0);
        wait_rst(1'h1);
        check_val({regEnable[7:4], regEnable[2:0], ext_core_enable}, 8'hFF);
        step(2);
        check_val(state, supply_seq_pkg::S_NORMAL);
        forceOver[supply_seq_pkg::R_COMM] <= 1'h1;
        step(150);
        forceOver <= 8'h00;
        step(5);
        check_val({flags.overV, regEnable[5]}, 9'h001);
        forceOver[supply_seq_pkg::R_COMM] <= 1'h1;
        step(215);
        check_val({flags.overV[5], regEnable[5], reset_out_n}, 3'h5);
        forceOver <= 8'h00;
        swEnable <= 8'hB0;
        swWrite <= 1'h1;
        step(1);
        swWrite <= 1'h0;
        step(20);
        check_val(regEnable[7:4], 4'hB);
        forceUnder[supply_seq_pkg::R_PRE] <= 1'h1;
        step(215);
        check_val({interruptOut, reset_out_n, regEnable[1]}, 3'h7);
        forceUnder <= 8'h00;
        step(2);
        check_val(flags.underV[1], 1'h1);
        flagClear <= 1'h1;
        step(1);
        flagClear <= 1'h0;
        step(2);
        check_val(flags, 25'h0000000);
        goSleep <= 1'h1;
        step(1);
        goSleep <= 1'h0;
        step(10);
        check_val({regEnable[7:4], reset_out_n}, 5'h01);
        wakeValid <= 1'h1;
        step(1);
        wakeValid <= 1'h0;
        step(60);
        check_val({regEnable[7:4], reset_out_n, state}, {4'hB, 1'h1, supply_seq_pkg::S_NORMAL});
        goStandby <= 1'h1;
        step(1);
        goStandby <= 1'h0;
        step(10);
        check_val({regEnable[7:4], regEnable[2:0], ext_core_enable}, 8'h02);
        wakeTimer <= 1'h1;
        step(1);
        wakeTimer <= 1'h0;
        wait_rst(1'h1);
        check_val({regEnable[2:0], ext_core_enable}, 4'hF);
        forceOver[supply_seq_pkg::R_CORE] <= 1'h1;
        step(215);
        check_val({ext_core_enable, reset_out_n, regEnable, state}, {2'h0, 8'h00, supply_seq_pkg::S_SAFE_SHUTDOWN_STATE});
        forceOver <= 8'h00;
        wait_rst(1'h1);
        overTemp <= 1'h1;
        step(5);
        overTemp <= 1'h0;
        check_val({flags.overTemp, regEnable, state}, {1'h1, 8'h00, supply_seq_pkg::S_SAFE_SHUTDOWN_STATE});
        step(60);
        check_val(state, supply_seq_pkg::S_SAFE_SHUTDOWN_STATE);
        wait_rst(1'h1);
        intSupplyFault <= 1'h1;
        step(2);
        check_val(reset_out_n, 1'h0);
        tally_and_finish;
    end
endmodule
